// [src/uxc_top.sv]
// Transceiver control, line status and indirect core register access
// Notes on behaviour
// - Speed clear is low speed, pull-up on D-; set is full speed, on D+.
// - Transceiver enable set is normal; clear is disabled and suspended.
// - While enabled, the diff bit reads the present differential value.
// - Two read-only bits show the live levels of the D+ and D- pins.
// - Core registers are reached only through the indirect pair.
// - Each data access goes to the core register held in the address reg.
// - Busy 1 starts a read, cleared when data is valid, 0 has no effect.
// - Pull-up enable clear keeps it off; set turns it on only with power.
`timescale 1ns/1ps
`include "uxc_regs.svh"
module uxc_top #(
	parameter int CORE_AW = 6
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Processor register port
	input wire uxc_pkg::uxc_sfr_req_t sfr_req_i,
	output logic [7:0] sfr_rdata_o,
	// Core register side
	output logic [CORE_AW-1:0] core_addr_o,
	output logic core_rd_o,
	output logic core_wr_o,
	output logic [7:0] core_wdata_o,
	input wire logic core_rvalid_i,
	input wire logic [7:0] core_rdata_i,
	// Bus power and transceiver controls
	input wire logic vbus_i,
	output logic phy_enable_o,
	output logic full_speed_o,
	output logic pullup_plus_o,
	output logic pullup_minus_o,
	// Line pins
	input wire logic plus_line_i,
	input wire logic minus_line_i,
	output logic plus_line_o,
	output logic plus_line_oe_o,
	output logic minus_line_o,
	output logic minus_line_oe_o
);

	// Elaboration check
	if (CORE_AW != 6) begin : g_bad_aw
		$error("core address width must be 6");
	end

	////////////////////////////////////////////////////////////////////////
	// Decode and register state
	uxc_pkg::uxc_xcvr_ctrl_t xcvr_ctrl_r;
	uxc_pkg::uxc_ind_addr_t ind_addr_r;
	uxc_pkg::uxc_rd_state_t rd_state_r;
	logic [7:0] ind_data_r;
	logic wr_xcvr;
	logic wr_addr;
	logic wr_data;
	logic rd_start;
	logic diff_state;
	logic [7:0] rd_mux;
	// Strobe decode
	assign wr_xcvr = sfr_req_i.wr && (sfr_req_i.addr == `UXC_OFS_XCVR_CTRL);
	assign wr_addr = sfr_req_i.wr && (sfr_req_i.addr == `UXC_OFS_IND_ADDR);
	assign wr_data = sfr_req_i.wr && (sfr_req_i.addr == `UXC_OFS_IND_DATA);
	assign rd_start = wr_addr && sfr_req_i.wdata[`UXC_IA_BUSY_BIT];
	// Differential value, held low while suspended
	assign diff_state = xcvr_ctrl_r.phy_enable_bit && plus_line_i
		&& !minus_line_i;
	////////////////////////////////////////////////////////////////////////
	// Transceiver control register
	// Writable control bits
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			xcvr_ctrl_r <= `UXC_RST_XCVR_CTRL;
		end else if (wr_xcvr) begin
			xcvr_ctrl_r <= sfr_req_i.wdata[`UXC_XC_PULLUP_BIT:`UXC_XC_TEST_LO];
		end
	end
	// Speed, enable and pull-up placement
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			phy_enable_o <= 1'b0;
			full_speed_o <= 1'b0;
			pullup_plus_o <= 1'b0;
			pullup_minus_o <= 1'b0;
		end else begin
			phy_enable_o <= xcvr_ctrl_r.phy_enable_bit;
			full_speed_o <= xcvr_ctrl_r.speed;
			pullup_plus_o <= xcvr_ctrl_r.pullup_enable && vbus_i
				&& xcvr_ctrl_r.speed;
			pullup_minus_o <= xcvr_ctrl_r.pullup_enable && vbus_i
				&& !xcvr_ctrl_r.speed;
		end
	end
	// Forced line levels, released while suspended or normal
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			plus_line_o <= 1'b0;
			minus_line_o <= 1'b0;
			plus_line_oe_o <= 1'b0;
			minus_line_oe_o <= 1'b0;
		end else begin
			plus_line_oe_o <= 1'b0;
			minus_line_oe_o <= 1'b0;
			plus_line_o <= 1'b0;
			minus_line_o <= 1'b0;
			if (xcvr_ctrl_r.phy_enable_bit) begin
				unique case (xcvr_ctrl_r.xcvr_test_mode)
					uxc_pkg::UXC_TEST_NORMAL: begin
						plus_line_oe_o <= 1'b0;
					end
					uxc_pkg::UXC_TEST_DIFF1: begin
						plus_line_oe_o <= 1'b1;
						minus_line_oe_o <= 1'b1;
						plus_line_o <= 1'b1;
					end
					uxc_pkg::UXC_TEST_DIFF0: begin
						plus_line_oe_o <= 1'b1;
						minus_line_oe_o <= 1'b1;
						minus_line_o <= 1'b1;
					end
					uxc_pkg::UXC_TEST_SE0: begin
						plus_line_oe_o <= 1'b1;
						minus_line_oe_o <= 1'b1;
					end
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Indirect access
	// Address register and busy flag; a new start wins over completion
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ind_addr_r <= `UXC_RST_IND_ADDR;
			rd_state_r <= uxc_pkg::UXC_ST_IDLE;
		end else begin
			if (wr_addr) begin
				ind_addr_r.auto_read_next <= sfr_req_i.wdata[`UXC_IA_AUTO_BIT];
				ind_addr_r.core_reg_select <= sfr_req_i.wdata[5:0];
			end
			unique case (rd_state_r)
				uxc_pkg::UXC_ST_IDLE: begin
					if (rd_start) begin
						rd_state_r <= uxc_pkg::UXC_ST_WAIT;
						ind_addr_r.busy <= 1'b1;
					end
				end
				uxc_pkg::UXC_ST_WAIT: begin
					if (!rd_start && core_rvalid_i) begin
						rd_state_r <= uxc_pkg::UXC_ST_IDLE;
						ind_addr_r.busy <= 1'b0;
					end
				end
			endcase
		end
	end

	// Data register: processor write or returned core data
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ind_data_r <= `UXC_RST_IND_DATA;
		end else if (wr_data) begin
			ind_data_r <= sfr_req_i.wdata;
		end else if (ind_addr_r.busy && core_rvalid_i) begin
			ind_data_r <= core_rdata_i;
		end
	end
	// Core side strobes, only from the indirect pair
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			core_addr_o <= '0;
			core_rd_o <= 1'b0;
			core_wr_o <= 1'b0;
			core_wdata_o <= 8'h00;
		end else begin
			if (wr_addr) begin
				core_addr_o <= sfr_req_i.wdata[CORE_AW-1:0];
			end
			core_rd_o <= rd_start;
			core_wr_o <= wr_data;
			if (wr_data) begin
				core_wdata_o <= sfr_req_i.wdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Read-back
	// Register read mux, unmapped reads give zero
	always_comb begin
		unique case (sfr_req_i.addr)
			`UXC_OFS_XCVR_CTRL: begin
				rd_mux = {xcvr_ctrl_r, diff_state, plus_line_i,
					minus_line_i};
			end
			`UXC_OFS_IND_ADDR: begin
				rd_mux = ind_addr_r;
			end
			`UXC_OFS_IND_DATA: begin
				rd_mux = ind_data_r;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end
	// Registered read data
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_req_i.rd) begin
			sfr_rdata_o <= rd_mux;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_start;
		rd_start && !rd_state_r;
	endsequence
	sequence s_launched;
		core_rd_o && ind_addr_r.busy;
	endsequence
	property p_speed_pullup;
		@(posedge clock_i) disable iff (reset_i)
		(wr_xcvr && vbus_i && sfr_req_i.wdata[7] && sfr_req_i.wdata[5])
		##1 (vbus_i && !wr_xcvr) |=> pullup_plus_o && !pullup_minus_o;
	endproperty
	a_speed_pullup: assert property (p_speed_pullup)
		else $error("pull-up not on plus line at full speed");
	property p_phy_en;
		@(posedge clock_i) disable iff (reset_i)
		wr_xcvr ##1 !wr_xcvr |=> phy_enable_o == $past(sfr_req_i.wdata[6], 2);
	endproperty
	a_phy_en: assert property (p_phy_en)
		else $error("transceiver enable does not follow write");
	property p_diff;
		@(posedge clock_i) disable iff (reset_i)
		sfr_req_i.rd && sfr_req_i.addr == `UXC_OFS_XCVR_CTRL
		&& xcvr_ctrl_r.phy_enable_bit
		|=> sfr_rdata_o[2] == $past(plus_line_i && !minus_line_i);
	endproperty
	a_diff: assert property (p_diff)
		else $error("differential bit wrong");
	property p_lines;
		@(posedge clock_i) disable iff (reset_i)
		sfr_req_i.rd && sfr_req_i.addr == `UXC_OFS_XCVR_CTRL
		|=> sfr_rdata_o[1:0] == $past({plus_line_i, minus_line_i});
	endproperty
	a_lines: assert property (p_lines)
		else $error("line level bits wrong");
	property p_only_pair;
		@(posedge clock_i) disable iff (reset_i)
		core_wr_o |-> $past(wr_data);
	endproperty
	a_only_pair: assert property (p_only_pair)
		else $error("core write without data register write");
	property p_data_target;
		@(posedge clock_i) disable iff (reset_i)
		wr_data && !wr_addr |=> core_wr_o
		&& core_addr_o == $past(ind_addr_r.core_reg_select);
	endproperty
	a_data_target: assert property (p_data_target)
		else $error("core write went to wrong address");
	property p_read_start;
		@(posedge clock_i) disable iff (reset_i)
		s_start |=> s_launched;
	endproperty
	a_read_start: assert property (p_read_start)
		else $error("read start not launched");
	property p_busy_clear;
		@(posedge clock_i) disable iff (reset_i)
		ind_addr_r.busy && core_rvalid_i && !rd_start
		|=> !ind_addr_r.busy && ind_data_r == $past(core_rdata_i);
	endproperty
	a_busy_clear: assert property (p_busy_clear)
		else $error("busy not cleared with data");
	property p_se0;
		@(posedge clock_i) disable iff (reset_i)
		xcvr_ctrl_r.phy_enable_bit && xcvr_ctrl_r.xcvr_test_mode == 2'b11
		|=> plus_line_oe_o && minus_line_oe_o && !plus_line_o
		&& !minus_line_o;
	endproperty
	a_se0: assert property (p_se0)
		else $error("single-ended zero not forced");
	property p_pullup_off;
		@(posedge clock_i) disable iff (reset_i)
		!xcvr_ctrl_r.pullup_enable || !vbus_i
		|=> !pullup_plus_o && !pullup_minus_o;
	endproperty
	a_pullup_off: assert property (p_pullup_off)
		else $error("pull-up on while disabled or unpowered");
endmodule

// [common/uxc_regs.svh]
// Offsets, field positions and reset values of the transceiver control block
`ifndef UXC_REGS_SVH
`define UXC_REGS_SVH

// Processor register offsets
`define UXC_OFS_XCVR_CTRL 8'hD7
`define UXC_OFS_IND_ADDR 8'h96
`define UXC_OFS_IND_DATA 8'h97

// Transceiver control fields
`define UXC_XC_PULLUP_BIT 7
`define UXC_XC_PHY_ENABLE_BIT_BIT 6
`define UXC_XC_SPEED_BIT 5
`define UXC_XC_TEST_HI 4
`define UXC_XC_TEST_LO 3
`define UXC_XC_DIFF_BIT 2
`define UXC_XC_PLUS_BIT 1
`define UXC_XC_MINUS_BIT 0

// Indirect address fields
`define UXC_IA_BUSY_BIT 7
`define UXC_IA_AUTO_BIT 6

// Reset values
`define UXC_RST_XCVR_CTRL 5'h00
`define UXC_RST_IND_ADDR 8'h00
`define UXC_RST_IND_DATA 8'h00

`endif

// [common/uxc_pkg.sv]
// Types shared by the transceiver control block
package uxc_pkg;

	// Forced line modes
	typedef enum logic [1:0] {
		UXC_TEST_NORMAL = 2'b00,
		UXC_TEST_DIFF1 = 2'b01,
		UXC_TEST_DIFF0 = 2'b10,
		UXC_TEST_SE0 = 2'b11
	} uxc_test_t;

	// Writable transceiver control bits
	typedef struct packed {
		logic pullup_enable;
		logic phy_enable_bit;
		logic speed;
		uxc_test_t xcvr_test_mode;
	} uxc_xcvr_ctrl_t;

	// Indirect address register layout
	typedef struct packed {
		logic busy;
		logic auto_read_next;
		logic [5:0] core_reg_select;
	} uxc_ind_addr_t;

	// Processor register request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} uxc_sfr_req_t;

	// Indirect read state
	typedef enum logic {
		UXC_ST_IDLE = 1'b0,
		UXC_ST_WAIT = 1'b1
	} uxc_rd_state_t;

endpackage

// [verification/uxc_core_model.sv]
// Core register file model answering indirect accesses
`timescale 1ns/1ps

module uxc_core_model #(
	parameter int DLY = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Core register side
	input wire logic [5:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic rvalid_o,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:1023];
	logic [3:0] idx;
	logic [9:0] key;
	int cnt;

	// Registers 0x10 to 0x1F belong to the endpoint in the index
	assign key = (addr_i[5:4] == 2'h1) ? {2'h1, idx, addr_i[3:0]} :
		{4'h0, addr_i};

	// Writes land at once, reads answer after DLY cycles
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cnt <= 0;
			idx <= 4'h0;
			rvalid_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (wr_i) begin
				mem[key] <= wdata_i;
				if (addr_i == 6'h0E) idx <= wdata_i[3:0];
			end
			if (rd_i) cnt <= DLY;
			else if (cnt > 1) cnt <= cnt - 1;
			else if (cnt == 1) begin
				cnt <= 0;
				rvalid_o <= 1'b1;
				rdata_o <= mem[key];
			end
		end
	end
endmodule

// [verification/test_usb_xcvr_ctrl_indirect_access.sv]
// Self-checking bench for the transceiver control block
`timescale 1ns/1ps
`include "uxc_regs.svh"

module test_usb_xcvr_ctrl_indirect_access;
	localparam logic [7:0] xc = `UXC_OFS_XCVR_CTRL;
	localparam logic [7:0] ia = `UXC_OFS_IND_ADDR;
	localparam logic [7:0] id = `UXC_OFS_IND_DATA;
	logic clock_i, reset_i, vbus, pl, ml, c_r, c_w, c_v;
	logic en, fs, pup, pum, po, poe, mo, moe;
	logic [7:0] rdata, c_wd, c_rd, d;
	logic [5:0] c_a;
	logic [3:0] tm [4] = '{4'h0, 4'hD, 4'h7, 4'h5};
	uxc_pkg::uxc_sfr_req_t req;
	int miscompares, n_checks;

	uxc_top i_uxc_top (.clock_i(clock_i), .reset_i(reset_i),
		.sfr_req_i(req), .sfr_rdata_o(rdata), .core_addr_o(c_a),
		.core_rd_o(c_r), .core_wr_o(c_w), .core_wdata_o(c_wd),
		.core_rvalid_i(c_v), .core_rdata_i(c_rd), .vbus_i(vbus),
		.phy_enable_o(en), .full_speed_o(fs), .pullup_plus_o(pup),
		.pullup_minus_o(pum), .plus_line_i(pl), .minus_line_i(ml),
		.plus_line_o(po), .plus_line_oe_o(poe), .minus_line_o(mo),
		.minus_line_oe_o(moe));
	uxc_core_model i_uxc_core_model (.clock_i(clock_i),
		.reset_i(reset_i), .addr_i(c_a), .rd_i(c_r), .wr_i(c_w),
		.wdata_i(c_wd), .rvalid_o(c_v), .rdata_o(c_rd));

	// Clock at 40 MHz
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_i) req <= '{1'b1, 1'b0, a, v};
		@(posedge clock_i) req <= '0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clock_i) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i) req <= '0;
		repeat (2) @(negedge clock_i);
		d = rdata;
	endtask

	task settle;
		repeat (2) @(negedge clock_i);
	endtask

	task line(input logic p, input logic m);
		@(posedge clock_i) {pl, ml} <= {p, m};
	endtask

	task ctl(input logic [7:0] e);
		chk("en fs pup pum", e, {4'h0, en, fs, pup, pum});
	endtask

	// Start a core read, poll busy, then fetch the data
	task idx_read(input logic [7:0] ep, input logic [7:0] e);
		wr(ia, 8'h0E);
		wr(id, ep);
		wr(ia, 8'h91);
		wr(ia, 8'h11);
		rd(ia);
		chk("busy held", 8'h91, d);
		for (int i = 0; i < 50 && d[7] !== 1'b0; i++) rd(ia);
		chk("busy clear", 8'h11, d);
		rd(id);
		chk("core data", e, d);
	endtask

	// Watchdog
	initial begin
		#(5000 * 25);
		miscompares++;
		report_and_stop;
	end

	// Main sequence
	initial begin
		reset_i = 1'b1;
		req = '0;
		vbus = 1'b1;
		pl = 1'b0;
		ml = 1'b0;
		miscompares = 0;
		n_checks = 0;
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		rd(ia);
		chk("addr reset", 8'h00, d);
		rd(xc);
		chk("xcvr reset", 8'h00, d);
		rd(8'h55);
		chk("unmapped", 8'h00, d);
		line(1'b1, 1'b0);
		wr(xc, 8'hE7);
		settle;
		ctl(8'h0E);
		rd(xc);
		chk("xcvr status", 8'hE6, d);
		wr(xc, 8'hC0);
		line(1'b0, 1'b1);
		settle;
		ctl(8'h09);
		rd(xc);
		chk("xcvr status", 8'hC1, d);
		@(posedge clock_i) vbus <= 1'b0;
		settle;
		ctl(8'h08);
		@(posedge clock_i) vbus <= 1'b1;
		wr(xc, 8'h40);
		settle;
		ctl(8'h08);
		line(1'b1, 1'b0);
		wr(xc, 8'h00);
		settle;
		ctl(8'h00);
		rd(xc);
		chk("xcvr off", 8'h02, d);
		for (int m = 0; m < 4; m++) begin
			wr(xc, 8'h40 | 8'(m << 3));
			settle;
			chk("test lines", {4'h0, tm[m]}, {4'h0, po, poe, mo, moe});
		end
		wr(xc, 8'h18);
		settle;
		chk("test off", 8'h00, {4'h0, po, poe, mo, moe});
		wr(ia, 8'h0E);
		wr(id, 8'h02);
		wr(ia, 8'h11);
		wr(id, 8'hA5);
		settle;
		chk("core addr", 8'h11, {2'h0, c_a});
		chk("core wdata", 8'hA5, c_wd);
		wr(ia, 8'h51);
		rd(ia);
		chk("auto bit", 8'h51, d);
		wr(ia, 8'h0E);
		wr(id, 8'h01);
		wr(ia, 8'h11);
		wr(id, 8'h3C);
		idx_read(8'h02, 8'hA5);
		idx_read(8'h01, 8'h3C);
		report_and_stop;
	end
endmodule
